// *** rtl/pclpir_pkg.sv ***
// Shared constants and types of the configuration register bank and codec link.
// Assumes the enclosing PCI target decodes configuration cycles into one-cycle requests.
package pclpir_pkg;

  // ----------------------------------------------------------------
  // Register offsets in configuration space
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_LINK_POWER_CONTROL = 8'hec;
  localparam logic [7:0] OFS_CONFIG_LOAD_BYTES = 8'hf0;
  localparam logic [7:0] OFS_ISA_IRQ_SELECT = 8'hf4;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'hf8;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int LPC_RELEASE_BIT = 0;
  localparam int LPC_FORCE_SYNC_BIT = 1;
  localparam int LPC_WAKE_PRI_BIT = 2;
  localparam int LPC_WAKE_SEC_BIT = 3;
  localparam int LPC_SECOND_IN_BIT = 8;
  localparam int LPC_EEPROM_DIS_BIT = 9;
  localparam int LPC_SEC_WAKE_EN_BIT = 14;
  localparam int LPC_PRI_WAKE_EN_BIT = 15;
  localparam logic [31:0] LPC_WRITE_MASK = 32'h0000_c303;
  localparam logic [31:0] LPC_RESET = 32'h0000_0000;
  localparam logic [31:0] CLB_RESET = 32'h0000_0000;

  localparam int ISA_AUX_SUPPORT_BIT = 31;
  localparam int ISA_AUX_CUR_LSB = 28;
  localparam int ISA_AUX_CUR_W = 3;
  localparam int ISA_AUX_POWER_BIT = 27;
  localparam int ISA_TRAP_DIS_BIT = 23;
  localparam int ISA_LEGACY_IRQ_PIN_C_LSB = 16;
  localparam int ISA_LEGACY_IRQ_PIN_B_LSB = 8;
  localparam int ISA_LEGACY_IRQ_PIN_A_LSB = 0;
  localparam int ISA_MAP_W = 4;
  localparam logic [31:0] ISA_WRITE_MASK = 32'hff8f_0f0f;
  localparam logic [31:0] ISA_RESET = 32'h0000_0000;

  localparam int IRQ_SRC_W = 8;

  // ----------------------------------------------------------------
  // Link frame layout
  // ----------------------------------------------------------------
  localparam int SLOT_W = 20;
  localparam logic [4:0] SLOT0_LAST_POS = 5'h0f;
  localparam logic [4:0] SLOT_LAST_POS = 5'h13;
  localparam logic [3:0] FRAME_LAST_SLOT = 4'hc;
  localparam logic [3:0] FIRST_DATA_SLOT = 4'h3;
  localparam logic [3:0] LAST_DATA_SLOT = 4'hb;
  localparam logic [15:0] TX_TAG_WORD = 16'h9ff0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int MCLK_PERIOD_NS = 5;
  localparam int LINK_IDLE_NS = 50000;
  localparam int LINK_IDLE_CYC = (LINK_IDLE_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } pclpir_cfg_req_type;

  typedef struct packed {
    logic aux_power_support;
    logic [ISA_AUX_CUR_W-1:0] aux_current_code;
    logic aux_power_bit;
  } pclpir_pm_caps_type;

  typedef struct packed {
    logic [3:0] slot;
    logic [SLOT_W-1:0] pri;
    logic [SLOT_W-1:0] sec;
  } pclpir_rx_rec_type;

  // Byte-enabled write limited to the writable bits of a register
  function automatic logic [31:0] merge_write(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
    return (old & ~m) | (wd & m);
  endfunction : merge_write

endpackage : pclpir_pkg

// *** rtl/pclpir_link.sv ***
// Link-side frame engine: slot counting, sync, serial output and input capture.
// Assumes bit_clk comes from the primary codec and may stop while the link is down.
`timescale 1ns/100ps
module pclpir_link (
  input wire logic bit_clk,
  input wire logic link_rst_req,
  input wire logic second_input_enable,
  input wire logic primary_serial_in,
  input wire logic secondary_serial_in,
  input wire logic tx_req_tgl,
  input wire logic [pclpir_pkg::SLOT_W-1:0] tx_word,
  output logic tx_ack_tgl,
  output pclpir_pkg::pclpir_rx_rec_type rx_rec,
  output logic rx_tgl,
  output logic [1:0] gp_rise_tgl,
  output logic frame_tgl,
  output logic sync_gen,
  output logic serial_data_out
);

  typedef struct packed {
    logic [1:0] rst_s;
    logic [1:0] sie_s;
    logic [1:0] req_s;
    logic ack;
    logic [3:0] slot;
    logic [4:0] pos;
    logic [pclpir_pkg::SLOT_W-1:0] tx_sh;
    logic [pclpir_pkg::SLOT_W-1:0] rx_p;
    logic [pclpir_pkg::SLOT_W-1:0] rx_s;
    pclpir_pkg::pclpir_rx_rec_type rec;
    logic rxt;
    logic [1:0] gp_prev;
    logic [1:0] gpt;
    logic frt;
    logic sync;
  } pclpir_link_state_type;

  pclpir_link_state_type q, d;

  // ----------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------
  // Link timing comes from the codec bit clock, nothing here free-runs
  always_comb begin
    logic last;
    logic [3:0] nslot;
    logic [pclpir_pkg::SLOT_W-1:0] pw;
    logic [pclpir_pkg::SLOT_W-1:0] sw;
    d = q;
    last = (q.slot == 4'h0) ? (q.pos == pclpir_pkg::SLOT0_LAST_POS) : (q.pos == pclpir_pkg::SLOT_LAST_POS);
    nslot = (q.slot == pclpir_pkg::FRAME_LAST_SLOT) ? 4'h0 : q.slot + 4'h1;
    pw = {q.rx_p[pclpir_pkg::SLOT_W-2:0], primary_serial_in};
    sw = {q.rx_s[pclpir_pkg::SLOT_W-2:0], secondary_serial_in & q.sie_s[1]};
    d.rst_s = {q.rst_s[0], link_rst_req};
    d.sie_s = {q.sie_s[0], second_input_enable};
    d.req_s = {q.req_s[0], tx_req_tgl};
    d.rx_p = pw;
    d.rx_s = sw;
    d.tx_sh = {q.tx_sh[pclpir_pkg::SLOT_W-2:0], 1'b0};
    d.pos = q.pos + 5'h1;
    if (last) begin
      d.pos = 5'h0;
      d.slot = nslot;
      if (nslot == 4'h0) begin
        d.tx_sh = {pclpir_pkg::TX_TAG_WORD, 4'h0};
      end else if (nslot >= pclpir_pkg::FIRST_DATA_SLOT && nslot <= pclpir_pkg::LAST_DATA_SLOT) begin
        // An empty slot goes out as zero; the mclk word is stable while req and ack differ
        d.tx_sh = '0;
        if (q.req_s[1] != q.ack) begin
          d.tx_sh = tx_word;
          d.ack = q.req_s[1];
        end
      end else begin
        d.tx_sh = '0;
      end
      if (q.slot >= pclpir_pkg::FIRST_DATA_SLOT && q.slot <= pclpir_pkg::LAST_DATA_SLOT) begin
        d.rec = '{slot: q.slot, pri: pw, sec: sw};
        d.rxt = ~q.rxt;
      end
      if (q.slot == pclpir_pkg::FRAME_LAST_SLOT) begin
        // Interrupt bit is the last bit of slot 12; compare with the previous frame per codec
        d.gp_prev = {sw[0], pw[0]};
        d.gpt = q.gpt ^ ({sw[0], pw[0]} & ~q.gp_prev);
        d.frt = ~q.frt;
      end
    end
    d.sync = (d.slot == 4'h0);
    if (q.rst_s[1]) begin
      d = '0;
      d.rst_s = {q.rst_s[0], link_rst_req};
    end
  end

  // Link-domain registers
  always_ff @(posedge bit_clk) begin
    q <= d;
  end

  assign tx_ack_tgl = q.ack;
  assign rx_rec = q.rec;
  assign rx_tgl = q.rxt;
  assign gp_rise_tgl = q.gpt;
  assign frame_tgl = q.frt;
  assign sync_gen = q.sync;
  assign serial_data_out = q.tx_sh[pclpir_pkg::SLOT_W-1];

endmodule : pclpir_link

// *** rtl/pclpir_regs.sv ***
// Vendor configuration registers for link power, wake, EEPROM, aux power and ISA interrupts.
// Assumes a PCI target front end decodes config cycles; the codec link runs on bit_clk.
`timescale 1ns/100ps
module pclpir_regs #(
  parameter int LINK_IDLE_CYC = pclpir_pkg::LINK_IDLE_CYC
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  // Configuration access
  input wire pclpir_pkg::pclpir_cfg_req_type cfg_req,
  output logic cfg_ack,
  output logic [31:0] cfg_rdata,
  input wire logic config_write_protect,
  input wire logic pci_rst_n,
  // EEPROM engine side
  input wire logic cfg_load_valid,
  input wire logic [31:0] cfg_load_data,
  output logic eeprom_read_start,
  output logic eeprom_engine_connect,
  // Power management and trapping
  output pclpir_pkg::pclpir_pm_caps_type pm_capabilities,
  output logic global_trap_disable,
  output logic pme_out,
  output logic pme_oe_n,
  // Interrupts
  input wire logic [pclpir_pkg::IRQ_SRC_W-1:0] irq_src,
  input wire logic [2:0] isa_irq_drive_en,
  output logic inta_out,
  output logic inta_oe_n,
  output logic legacy_irq_pin_a_out,
  output logic legacy_irq_pin_a_oe_n,
  output logic legacy_irq_pin_b_out,
  output logic legacy_irq_pin_b_oe_n,
  output logic legacy_irq_pin_c_out,
  output logic legacy_irq_pin_c_oe_n,
  // Sample streams
  input wire logic tx_valid,
  input wire logic [pclpir_pkg::SLOT_W-1:0] tx_word,
  output logic tx_ready,
  output logic rx_valid,
  output pclpir_pkg::pclpir_rx_rec_type rx_data,
  output logic gpio1_in,
  // Codec link pins
  input wire logic bit_clk,
  input wire logic primary_serial_in,
  input wire logic secondary_serial_in,
  output logic codec_link_reset_out_n,
  output logic link_sync_out,
  output logic serial_data_out
);

  typedef struct packed {
    logic [31:0] lpc;
    logic [31:0] clb;
    logic [31:0] iis;
    logic [pclpir_pkg::IRQ_SRC_W-1:0] ist;
    logic [31:0] rdata;
    logic ack;
    logic [1:0] prst_s;
    logic [1:0] sdi1_s;
    logic [1:0] sdi2_s;
    logic sdi1_d;
    logic sdi2_d;
    logic [2:0] frm_s;
    logic [2:0] rxt_s;
    logic [2:0] gpp_s;
    logic [2:0] gps_s;
    logic [1:0] ack_s;
    logic tx_req;
    logic [pclpir_pkg::SLOT_W-1:0] tx_word;
    logic [15:0] idle_cnt;
    logic link_up;
    logic force_d;
    logic [1:0] pme;
    logic eep_done;
    logic eep_go;
    logic rx_valid;
    pclpir_pkg::pclpir_rx_rec_type rx;
  } pclpir_state_type;

  pclpir_state_type q, d;

  logic l_ack_tgl;
  logic l_rx_tgl;
  logic l_frame_tgl;
  logic l_sync;
  logic [1:0] l_gp_tgl;
  pclpir_pkg::pclpir_rx_rec_type l_rec;
  logic link_rst_req;
  logic inta_active;

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  // Unmapped offsets read as zero so the config space stays clean
  function automatic logic [31:0] read_reg(input pclpir_state_type s, input logic [7:0] addr);
    logic [31:0] v;
    v = '0;
    case (addr)
      pclpir_pkg::OFS_LINK_POWER_CONTROL: v = s.lpc;
      pclpir_pkg::OFS_CONFIG_LOAD_BYTES: v = s.clb;
      pclpir_pkg::OFS_ISA_IRQ_SELECT: v = s.iis;
      pclpir_pkg::OFS_IRQ_STATUS: v = {{(32 - pclpir_pkg::IRQ_SRC_W){1'b0}}, s.ist};
      default: v = '0;
    endcase
    return v;
  endfunction : read_reg

  // Mapping field of one ISA pin is non-zero
  function automatic logic map_set(input logic [31:0] iis, input int lsb);
    return (iis[lsb +: pclpir_pkg::ISA_MAP_W] != '0);
  endfunction : map_set

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_ok;
    logic prim_rise;
    logic sec_rise;
    logic link_down;
    logic warm_end;
    logic gpp_ev;
    logic gps_ev;
    logic [31:0] w1c;
    d = q;
    {prim_rise, sec_rise, link_down, warm_end, gpp_ev, gps_ev} = '0;
    w1c = '0;
    wr_ok = cfg_req.wr & config_write_protect;

    // Pin synchronisers; first stages feed only second stages
    d.prst_s = {q.prst_s[0], ~pci_rst_n};
    d.sdi1_s = {q.sdi1_s[0], primary_serial_in};
    d.sdi2_s = {q.sdi2_s[0], secondary_serial_in};
    d.sdi1_d = q.sdi1_s[1];
    d.sdi2_d = q.sdi2_s[1];
    d.frm_s = {q.frm_s[1:0], l_frame_tgl};
    d.rxt_s = {q.rxt_s[1:0], l_rx_tgl};
    d.gpp_s = {q.gpp_s[1:0], l_gp_tgl[0]};
    d.gps_s = {q.gps_s[1:0], l_gp_tgl[1]};
    d.ack_s = {q.ack_s[0], l_ack_tgl};

    // Config register writes; PCI reset never reaches these registers
    if (wr_ok && cfg_req.addr == pclpir_pkg::OFS_LINK_POWER_CONTROL) begin
      d.lpc = pclpir_pkg::merge_write(q.lpc, cfg_req.wdata, cfg_req.be, pclpir_pkg::LPC_WRITE_MASK);
    end
    if (wr_ok && cfg_req.addr == pclpir_pkg::OFS_CONFIG_LOAD_BYTES) begin
      d.clb = pclpir_pkg::merge_write(q.clb, cfg_req.wdata, cfg_req.be, '1);
    end
    if (wr_ok && cfg_req.addr == pclpir_pkg::OFS_ISA_IRQ_SELECT) begin
      d.iis = pclpir_pkg::merge_write(q.iis, cfg_req.wdata, cfg_req.be, pclpir_pkg::ISA_WRITE_MASK);
    end
    // EEPROM load overrides a firmware write landing in the same cycle
    if (cfg_load_valid) begin
      d.clb = cfg_load_data;
    end

    // Interrupt status: write one clears, a new event in the same cycle wins
    w1c = '0;
    if (cfg_req.wr && cfg_req.addr == pclpir_pkg::OFS_IRQ_STATUS) begin
      w1c = pclpir_pkg::merge_write('0, cfg_req.wdata, cfg_req.be, '1);
    end
    d.ist = (q.ist & ~w1c[pclpir_pkg::IRQ_SRC_W-1:0]) | irq_src;

    // Read answer one cycle after the request
    d.ack = cfg_req.rd | cfg_req.wr;
    if (cfg_req.rd) begin
      d.rdata = read_reg(q, cfg_req.addr);
    end

    // Link activity watch: frames stop arriving when the bit clock stops
    if (q.frm_s[2] != q.frm_s[1]) begin
      d.idle_cnt = '0;
      d.link_up = 1'b1;
    end else if (q.idle_cnt >= 16'(LINK_IDLE_CYC - 1)) begin
      d.link_up = 1'b0;
    end else begin
      d.idle_cnt = q.idle_cnt + 16'h1;
    end
    if (link_rst_req) begin
      d.link_up = 1'b0;
    end

    // Wake flags from a codec signalling on its data line while the link is down
    link_down = ~q.link_up | link_rst_req;
    prim_rise = q.sdi1_s[1] & ~q.sdi1_d;
    sec_rise = q.sdi2_s[1] & ~q.sdi2_d & q.lpc[pclpir_pkg::LPC_SECOND_IN_BIT];
    d.force_d = q.lpc[pclpir_pkg::LPC_FORCE_SYNC_BIT];
    warm_end = q.force_d & ~q.lpc[pclpir_pkg::LPC_FORCE_SYNC_BIT];
    if (warm_end) begin
      d.lpc[pclpir_pkg::LPC_WAKE_PRI_BIT] = 1'b0;
      d.lpc[pclpir_pkg::LPC_WAKE_SEC_BIT] = 1'b0;
    end
    if (prim_rise && link_down) begin
      d.lpc[pclpir_pkg::LPC_WAKE_PRI_BIT] = 1'b1;
    end
    if (sec_rise && link_down) begin
      d.lpc[pclpir_pkg::LPC_WAKE_SEC_BIT] = 1'b1;
    end

    // Slot-12 interrupt rises; the event holds until its enable (for the secondary, also the second-input bit) is cleared
    gpp_ev = q.gpp_s[2] != q.gpp_s[1];
    gps_ev = q.gps_s[2] != q.gps_s[1];
    if (!q.lpc[pclpir_pkg::LPC_PRI_WAKE_EN_BIT]) begin
      d.pme[0] = 1'b0;
    end else if (gpp_ev) begin
      d.pme[0] = 1'b1;
    end
    if (!q.lpc[pclpir_pkg::LPC_SEC_WAKE_EN_BIT] || !q.lpc[pclpir_pkg::LPC_SECOND_IN_BIT]) begin
      d.pme[1] = 1'b0;
    end else if (gps_ev) begin
      d.pme[1] = 1'b1;
    end

    // Received slot records; held for a whole slot on the link side
    d.rx_valid = q.rxt_s[2] != q.rxt_s[1];
    if (q.rxt_s[2] != q.rxt_s[1]) begin
      d.rx = l_rec;
    end

    // Transmit word handshake toward the link domain
    if (tx_valid && tx_ready) begin
      d.tx_word = tx_word;
      d.tx_req = ~q.tx_req;
    end

    // Single start-up EEPROM read, issued while the disable bit still holds its reset zero, so never skipped
    d.eep_go = 1'b0;
    if (!q.eep_done) begin
      d.eep_done = 1'b1;
      d.eep_go = ~q.lpc[pclpir_pkg::LPC_EEPROM_DIS_BIT];
    end

    if (!ce) begin
      d = q;
    end
    if (!nrst) begin
      d = '0;
      d.lpc = pclpir_pkg::LPC_RESET;
      d.clb = pclpir_pkg::CLB_RESET;
      d.iis = pclpir_pkg::ISA_RESET;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // One register for the whole mclk domain
  always_ff @(posedge mclk) begin
    q <= d;
  end

  // ----------------------------------------------------------------
  // Link domain
  // ----------------------------------------------------------------
  // Synced PCI reset keeps the codec in reset with the release bit
  assign link_rst_req = ~q.lpc[pclpir_pkg::LPC_RELEASE_BIT] | q.prst_s[1];

  pclpir_link u_link (
    .bit_clk(bit_clk),
    .link_rst_req(link_rst_req),
    .second_input_enable(q.lpc[pclpir_pkg::LPC_SECOND_IN_BIT]),
    .primary_serial_in(primary_serial_in),
    .secondary_serial_in(secondary_serial_in),
    .tx_req_tgl(q.tx_req),
    .tx_word(q.tx_word),
    .tx_ack_tgl(l_ack_tgl),
    .rx_rec(l_rec),
    .rx_tgl(l_rx_tgl),
    .gp_rise_tgl(l_gp_tgl),
    .frame_tgl(l_frame_tgl),
    .sync_gen(l_sync),
    .serial_data_out(serial_data_out)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Codec link pins; forced sync is a plain OR so it works with the bit clock stopped
  assign codec_link_reset_out_n = ~link_rst_req;
  assign link_sync_out = q.lpc[pclpir_pkg::LPC_FORCE_SYNC_BIT] | l_sync;

  // Pin function of the second data input
  assign gpio1_in = q.sdi2_s[1] & ~q.lpc[pclpir_pkg::LPC_SECOND_IN_BIT];

  // EEPROM engine control
  assign eeprom_read_start = q.eep_go;
  assign eeprom_engine_connect = ~q.lpc[pclpir_pkg::LPC_EEPROM_DIS_BIT];

  // Capability mirrors, read by the power management capability block
  assign pm_capabilities.aux_power_support = q.iis[pclpir_pkg::ISA_AUX_SUPPORT_BIT];
  assign pm_capabilities.aux_current_code =
    q.iis[pclpir_pkg::ISA_AUX_CUR_LSB +: pclpir_pkg::ISA_AUX_CUR_W];
  assign pm_capabilities.aux_power_bit = q.iis[pclpir_pkg::ISA_AUX_POWER_BIT];
  assign global_trap_disable = q.iis[pclpir_pkg::ISA_TRAP_DIS_BIT];

  // Open-drain power event pin, pulled low while any event stands
  assign pme_out = 1'b0;
  assign pme_oe_n = ~(|q.pme);

  // Host line is the OR of every pending source
  assign inta_active = |q.ist;
  assign inta_out = 1'b0;
  assign inta_oe_n = ~inta_active;

  // ISA pins follow the host line; a zero mapping or no driver enable floats the pin
  assign legacy_irq_pin_a_out = inta_active;
  assign legacy_irq_pin_b_out = inta_active;
  assign legacy_irq_pin_c_out = inta_active;
  assign legacy_irq_pin_a_oe_n = ~(map_set(q.iis, pclpir_pkg::ISA_LEGACY_IRQ_PIN_A_LSB) & isa_irq_drive_en[0]);
  assign legacy_irq_pin_b_oe_n = ~(map_set(q.iis, pclpir_pkg::ISA_LEGACY_IRQ_PIN_B_LSB) & isa_irq_drive_en[1]);
  assign legacy_irq_pin_c_oe_n = ~(map_set(q.iis, pclpir_pkg::ISA_LEGACY_IRQ_PIN_C_LSB) & isa_irq_drive_en[2]);

  // Streams and config answer
  assign tx_ready = (q.tx_req == q.ack_s[1]);
  assign rx_valid = q.rx_valid;
  assign rx_data = q.rx;
  assign cfg_ack = q.ack;
  assign cfg_rdata = q.rdata;

endmodule : pclpir_regs

// *** test/pclpir_sva.sv ***
// Port checker of the config register bank.
// Assumes it is bound onto pclpir_regs.
`timescale 1ns/100ps
module pclpir_sva (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic ce,
  input wire pclpir_pkg::pclpir_cfg_req_type cfg_req,
  input wire logic cfg_ack,
  input wire logic [31:0] cfg_rdata,
  input wire logic pci_rst_n,
  input wire logic [7:0] irq_src,
  input wire pclpir_pkg::pclpir_pm_caps_type pm_capabilities,
  input wire logic global_trap_disable,
  input wire logic inta_oe_n,
  input wire logic legacy_irq_pin_a_oe_n,
  input wire logic codec_link_reset_out_n,
  input wire logic link_sync_out
);
  // ----
  // Properties
  // ----
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Read taken, answered a cycle later; outputs are tied to the returned value
  sequence s_rd(logic [7:0] a);
    ce && cfg_req.rd && cfg_req.addr == a ##1 cfg_ack;
  endsequence
  a_pci_rst_hold: assert property (!pci_rst_n [*4] |-> !codec_link_reset_out_n)
    else $error("codec reset not held");
  a_release_low: assert property (s_rd(8'hec) ##0 !cfg_rdata[0] |-> !codec_link_reset_out_n)
    else $error("codec reset released");
  a_force_sync: assert property (s_rd(8'hec) ##0 cfg_rdata[1] |-> link_sync_out)
    else $error("sync not forced");
  a_pm_mirror: assert property (s_rd(8'hf4) |-> pm_capabilities == cfg_rdata[31:27])
    else $error("pm caps differ");
  a_trap_mirror: assert property (s_rd(8'hf4) |-> global_trap_disable == cfg_rdata[23])
    else $error("trap disable differs");
  a_isa_float: assert property (s_rd(8'hf4) ##0 cfg_rdata[3:0] == 4'h0 |-> legacy_irq_pin_a_oe_n)
    else $error("pin a driven");
  a_power_float: assert property ($rose(nrst) |-> legacy_irq_pin_a_oe_n && inta_oe_n)
    else $error("pins driven at start");
  a_irq_merge: assert property (ce && irq_src != 8'h00 |-> ##[1:3] !inta_oe_n)
    else $error("host irq missing");
endmodule : pclpir_sva

bind pclpir_regs pclpir_sva u_sva (.mclk, .nrst, .ce, .cfg_req, .cfg_ack, .cfg_rdata, .pci_rst_n, .irq_src,
  .pm_capabilities, .global_trap_disable, .inta_oe_n, .legacy_irq_pin_a_oe_n, .codec_link_reset_out_n,
  .link_sync_out);

// *** test/pclpir_codec.sv ***
// Codec model: bit clock master and both data inputs.
// Assumes sync is driven on bit_clk rising edges.
`timescale 1ns/100ps
module pclpir_codec (
  input wire logic rst_n,
  input wire logic sync,
  input wire logic wake,
  input wire logic gp,
  output logic bit_clk,
  output logic sdi1,
  output logic sdi2
);
  // ----
  // Model
  // ----
  logic [7:0] pos = 8'h00;
  logic sync_q = 1'b0;
  logic d_q = 1'b0;
  // Clock runs through reset so the link side can clear itself; odd offset keeps it unrelated to mclk
  initial begin
    bit_clk = 1'b0;
    #1.3;
    forever #62.5 bit_clk = ~bit_clk;
  end
  // Frame position from sync rise; gp is sent around the end of slot 12
  always @(negedge bit_clk) begin
    sync_q <= sync;
    pos <= (sync && !sync_q) ? 8'h01 : pos + 8'h01;
    d_q <= (pos > 8'hef || pos < 8'h04) ? gp : pos[0] ^ pos[3];
  end
  // Only the data input differs between the two codecs
  assign sdi1 = rst_n ? d_q : wake;
  assign sdi2 = rst_n ? ~d_q : wake;
endmodule : pclpir_codec

// *** test/pclpir_regs_tb_top.sv ***
// Bench of pclpir_regs with the codec model.
// Assumes the checker is bound by its own file.
`timescale 1ns/100ps
module pclpir_regs_tb_top;
  // ----
  // Bench
  // ----
  logic mclk, nrst, config_write_protect, pci_rst_n, tx_valid, wake, gp, cfg_ack, eeprom_read_start;
  logic pme_oe_n, inta_oe_n, tx_ready, rx_valid, bit_clk, legacy_irq_pin_a_oe_n, primary_serial_in;
  logic secondary_serial_in, codec_link_reset_out_n, link_sync_out;
  logic [7:0] irq_src;
  logic [2:0] isa_irq_drive_en;
  logic [19:0] tx_word;
  logic [31:0] cfg_rdata, rd, v;
  pclpir_pkg::pclpir_cfg_req_type cfg_req;
  logic cfg_load_valid;
  logic [31:0] cfg_load_data;
  int seed = 14, n_errors = 0, n_checks = 0, n_start = 0, n_rx = 0;
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  pclpir_regs uut (.mclk, .nrst, .ce(1'b1), .cfg_req, .cfg_ack, .cfg_rdata, .config_write_protect, .pci_rst_n,
    .cfg_load_valid, .cfg_load_data, .eeprom_read_start, .eeprom_engine_connect(),
    .pm_capabilities(), .global_trap_disable(), .pme_out(), .pme_oe_n, .irq_src, .isa_irq_drive_en,
    .inta_out(), .inta_oe_n, .legacy_irq_pin_a_out(), .legacy_irq_pin_a_oe_n, .legacy_irq_pin_b_out(),
    .legacy_irq_pin_b_oe_n(), .legacy_irq_pin_c_out(), .legacy_irq_pin_c_oe_n(), .tx_valid, .tx_word,
    .tx_ready, .rx_valid, .rx_data(), .gpio1_in(), .bit_clk, .primary_serial_in, .secondary_serial_in,
    .codec_link_reset_out_n, .link_sync_out, .serial_data_out());
  pclpir_codec codec (.rst_n(codec_link_reset_out_n), .sync(link_sync_out), .wake, .gp, .bit_clk,
    .sdi1(primary_serial_in), .sdi2(secondary_serial_in));
  // Start pulses counted; a fresh word once the last one is taken
  always @(posedge mclk) begin
    if (eeprom_read_start === 1'b1) n_start++;
    if (rx_valid === 1'b1) n_rx++;
    if (tx_ready !== 1'b0) tx_word <= 20'($random(seed));
  end
  function automatic logic f_oe(input logic [3:0] m, input logic e);
    return !(m != 4'h0 && e);
  endfunction : f_oe
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cfg(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    #1 cfg_req = '{w, !w, a, 4'hf, d};
    @(posedge mclk);
    #1 cfg_req = '0;
    rd = cfg_rdata;
  endtask : cfg
  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  // Protected writes, then random values with write permission
  initial begin
    {nrst, config_write_protect, wake, gp, irq_src, isa_irq_drive_en, cfg_load_valid, cfg_load_data} = '0;
    {pci_rst_n, tx_valid} = 2'b11;
    cfg_req = '0;
    repeat (12) @(posedge mclk);
    #1 nrst = 1'b1;
    for (int i = 0; i < 3; i++) begin
      v = 32'hec + 4 * i;
      cfg(1'b1, v[7:0], 32'hffff_ffff);
      cfg(1'b0, v[7:0], 32'h0);
      chk("protected", rd, 32'h0);
    end
    chk("eeprom start", n_start, 1);
    // Load from the EEPROM side lands even with writes protected
    @(posedge mclk);
    #1 cfg_load_valid = 1'b1;
    cfg_load_data = $random(seed);
    @(posedge mclk);
    #1 cfg_load_valid = 1'b0;
    cfg(1'b0, 8'hf0, 32'h0);
    chk("eeprom load", rd, cfg_load_data);
    config_write_protect = 1'b1;
    for (int i = 0; i < 2; i++) begin
      v = $random(seed);
      if (i == 0) v[3:0] = 4'h0;
      isa_irq_drive_en = 3'($random(seed));
      cfg(1'b1, 8'hf0, ~v);
      cfg(1'b0, 8'hf0, 32'h0);
      chk("load bytes", rd, ~v);
      cfg(1'b1, 8'hf4, v);
      cfg(1'b0, 8'hf4, 32'h0);
      chk("isa select", rd, v & pclpir_pkg::ISA_WRITE_MASK);
      chk("pin a", legacy_irq_pin_a_oe_n, f_oe(v[3:0], isa_irq_drive_en[0]));
    end
    $display("test registers done");
    // PCI reset, wake while held, warm reset, host interrupt
    pci_rst_n = 1'b0;
    repeat (5) @(posedge mclk);
    #1 chk("codec reset", codec_link_reset_out_n, 1'b0);
    pci_rst_n = 1'b1;
    cfg(1'b0, 8'hf4, 32'h0);
    chk("isa kept", rd, v & pclpir_pkg::ISA_WRITE_MASK);
    wake = 1'b1;
    repeat (8) @(posedge mclk);
    #1 wake = 1'b0;
    cfg(1'b0, 8'hec, 32'h0);
    chk("wake flags", rd & 32'hc, 32'h4);
    cfg(1'b1, 8'hec, 32'h2);
    cfg(1'b0, 8'hec, 32'h0);
    chk("forced sync", link_sync_out, 1'b1);
    cfg(1'b1, 8'hec, 32'h0);
    cfg(1'b0, 8'hec, 32'h0);
    chk("wake cleared", rd & 32'hc, 32'h0);
    irq_src = 8'($random(seed)) | 8'h01;
    @(posedge mclk);
    #1 irq_src = 8'h00;
    repeat (3) @(posedge mclk);
    #1 chk("host irq", inta_oe_n, 1'b0);
    cfg(1'b1, 8'hf8, 32'hff);
    repeat (2) @(posedge mclk);
    #1 chk("irq clear", inta_oe_n, 1'b1);
    $display("test wake done");
    // Link up; a slot 12 rise from the primary codec raises the event
    cfg(1'b1, 8'hec, 32'h8001);
    repeat (15000) @(posedge mclk);
    #1 chk("no event", pme_oe_n, 1'b1);
    gp = 1'b1;
    repeat (15000) @(posedge mclk);
    #1 chk("power event", pme_oe_n, 1'b0);
    chk("rx slots", n_rx != 0, 1);
    $display("test link done");
    end_of_test;
  end
  // Watchdog, over twice the expected run
  initial begin
    #400000;
    n_errors++;
    end_of_test;
  end
endmodule : pclpir_regs_tb_top
